// ==== logic/ccp_capture_edge.sv ====
`timescale 1ns/1ns
module ccp_capture_edge #(
   parameter int N = ccp_pkg::SRC_NUM
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [N-1:0] raw_in,
   input  wire logic [3:0]   src_sel,
   input  wire logic [3:0]   mode,
   input  wire logic         active,
   output logic              cap_q
);
   logic [N-1:0] sync1_q;
   logic [N-1:0] sync2_q;
   logic         prev_q;
   logic [3:0]   cnt_q;
   logic         sel;
   logic         src_ok;
   logic         rise;
   logic         fall;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   always_comb begin
      src_ok = (src_sel <= ccp_pkg::SRC_MAX);
      sel    = src_ok ? sync2_q[src_sel] : 1'b0;
      rise   = src_ok && sel && !prev_q;
      fall   = src_ok && !sel && prev_q;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= sel;
      end
   end

   // Prescale counter for the every-4th and every-16th modes
   always_ff @(posedge clk) begin
      if (!rst_n || !active) begin
         cnt_q <= '0;
      end else if (rise) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || !active) begin
         cap_q <= 1'b0;
      end else begin
         case (mode)
            ccp_pkg::CCP_CAP_RISE16: cap_q <= rise && (cnt_q == ccp_pkg::PRE_16);
            ccp_pkg::CCP_CAP_RISE4:  cap_q <= rise && (cnt_q[1:0] == ccp_pkg::PRE_4[1:0]);
            ccp_pkg::CCP_CAP_RISE:   cap_q <= rise;
            ccp_pkg::CCP_CAP_FALL:   cap_q <= fall;
            ccp_pkg::CCP_CAP_BOTH:   cap_q <= rise || fall;
            default:                 cap_q <= 1'b0;
         endcase
      end
   end

   a_cap_only_active: assert property (@(posedge clk) disable iff (!rst_n)
      cap_q |-> $past(active)) else $error("capture while inactive");
endmodule

// ==== logic/ccp_pkg.sv ====
package ccp_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0] OFF_MODE  = 8'h00;
   localparam logic [7:0] OFF_CAP   = 8'h04;
   localparam logic [7:0] OFF_LOW   = 8'h08;
   localparam logic [7:0] OFF_HIGH  = 8'h0c;
   localparam logic [7:0] OFF_TMRS  = 8'h10;
   // Field positions
   localparam int EN_BIT  = 7;
   localparam int OUT_BIT = 5;
   localparam int FMT_BIT = 4;
   // Reset values
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [3:0] CAP_RST  = 4'h0;
   localparam logic [7:0] VAL_RST  = 8'h00;
   localparam logic [7:0] TMRS_RST = 8'h55;
   // Capture source codes
   localparam logic [3:0] SRC_MAX  = 4'h8;
   localparam int         SRC_NUM  = 9;
   // Capture prescale counts
   localparam logic [3:0] PRE_16   = 4'hf;
   localparam logic [3:0] PRE_4    = 4'h3;
   // Timer selection codes
   localparam logic [1:0] TSEL_A   = 2'h0;
   localparam logic [1:0] TSEL_B   = 2'h1;
   localparam logic [1:0] TSEL_C   = 2'h2;

   typedef enum logic [3:0] {
      CCP_OFF        = 4'b0000,
      CCP_CMP_TGL_CL = 4'b0001,
      CCP_CMP_TGL    = 4'b0010,
      CCP_CAP_BOTH   = 4'b0011,
      CCP_CAP_FALL   = 4'b0100,
      CCP_CAP_RISE   = 4'b0101,
      CCP_CAP_RISE4  = 4'b0110,
      CCP_CAP_RISE16 = 4'b0111,
      CCP_CMP_SET    = 4'b1000,
      CCP_CMP_CLR    = 4'b1001,
      CCP_CMP_PLS    = 4'b1010,
      CCP_CMP_PLS_CL = 4'b1011,
      CCP_RSV_C      = 4'b1100,
      CCP_RSV_D      = 4'b1101,
      CCP_RSV_E      = 4'b1110,
      CCP_PWM        = 4'b1111
   } ccp_mode_t;
endpackage

// ==== logic/ccp_unit.sv ====
`timescale 1ns/1ns
module ccp_unit #(
   parameter int UNIT = 0
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [15:0] sixteen_bit_timer_0,
   input  wire logic [15:0] sixteen_bit_timer_1,
   input  wire logic [15:0] sixteen_bit_timer_3,
   input  wire logic [15:0] sixteen_bit_timer_5,
   input  wire logic [7:0]  period_timer_2,
   input  wire logic [7:0]  period_timer_4,
   input  wire logic [7:0]  period_timer_6,
   input  wire logic [7:0]  period_register_2,
   input  wire logic [7:0]  period_register_4,
   input  wire logic [7:0]  period_register_6,
   input  wire logic        period_tick_2,
   input  wire logic        period_tick_4,
   input  wire logic        period_tick_6,
   input  wire logic        adc_source_is_unit,
   input  wire logic        routed_pin_input,
   input  wire logic        comparator_1_output,
   input  wire logic        comparator_2_output,
   input  wire logic        numeric_oscillator_output,
   input  wire logic        pin_change_event,
   input  wire logic [3:0]  logic_cell_output,
   output logic             ccp_out,
   output logic             ccp_oe,
   output logic             match_event_flag,
   output logic             adc_trigger,
   output logic             timer_clear,
   output logic [1:0]       timer_clear_sel,
   output logic             period_clear
);
   logic [7:0]  mode_control_q;
   logic [3:0]  capture_source_field_q;
   logic [7:0]  value_low_byte_q;
   logic [7:0]  value_high_byte_q;
   logic [7:0]  unit_timer_select_q;
   logic        out_q;
   logic        pulse_q;
   logic        eq_prev_q;
   logic [1:0]  phase_q;
   logic [9:0]  duty_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        oe_q;
   logic        event_q;
   logic        adc_q;
   logic        tclr_q;
   logic        pclr_q;

   logic        unit_enable_bit;
   logic        width_alignment_bit;
   ccp_pkg::ccp_mode_t function_code;
   logic [1:0]  timer_selection_field;
   logic        active;
   logic [15:0] ctimer;
   logic [7:0]  ptimer;
   logic [7:0]  pperiod;
   logic        ptick;
   logic [9:0]  pulse_width_value;
   logic        is_cmp;
   logic        is_cap;
   logic        is_pwm;
   logic        eq;
   logic        match;
   logic        cap_ev;
   logic        pwm_end;
   logic        pwm_hit;
   logic        wr_en;
   logic        rd_en;
   logic [8:0]  cap_raw;

   // Selection field of this unit in the shared register
   function automatic logic [1:0] tsel_field(input logic [7:0] r, input int u);
      tsel_field = r[2*u +: 2];
   endfunction

   function automatic logic mode_is_cmp(input ccp_pkg::ccp_mode_t m);
      case (m)
         ccp_pkg::CCP_CMP_TGL_CL, ccp_pkg::CCP_CMP_TGL, ccp_pkg::CCP_CMP_SET,
         ccp_pkg::CCP_CMP_CLR, ccp_pkg::CCP_CMP_PLS, ccp_pkg::CCP_CMP_PLS_CL: mode_is_cmp = 1'b1;
         default: mode_is_cmp = 1'b0;
      endcase
   endfunction

   function automatic logic mode_is_cap(input ccp_pkg::ccp_mode_t m);
      case (m)
         ccp_pkg::CCP_CAP_BOTH, ccp_pkg::CCP_CAP_FALL, ccp_pkg::CCP_CAP_RISE,
         ccp_pkg::CCP_CAP_RISE4, ccp_pkg::CCP_CAP_RISE16: mode_is_cap = 1'b1;
         default: mode_is_cap = 1'b0;
      endcase
   endfunction

   always_comb begin
      unit_enable_bit       = mode_control_q[ccp_pkg::EN_BIT];
      width_alignment_bit   = mode_control_q[ccp_pkg::FMT_BIT];
      function_code         = ccp_pkg::ccp_mode_t'(mode_control_q[3:0]);
      timer_selection_field = tsel_field(unit_timer_select_q, UNIT);
      active = unit_enable_bit && (function_code != ccp_pkg::CCP_OFF);
      is_cmp = active && mode_is_cmp(function_code);
      is_cap = active && mode_is_cap(function_code);
      is_pwm = active && (function_code == ccp_pkg::CCP_PWM);
   end

   // Timer routing by selection code
   always_comb begin
      case (timer_selection_field)
         ccp_pkg::TSEL_A: ctimer = sixteen_bit_timer_0;
         ccp_pkg::TSEL_B: ctimer = sixteen_bit_timer_1;
         ccp_pkg::TSEL_C: ctimer = sixteen_bit_timer_3;
         default:         ctimer = sixteen_bit_timer_5;
      endcase
      case (timer_selection_field)
         ccp_pkg::TSEL_A, ccp_pkg::TSEL_B: begin
            ptimer  = period_timer_2;
            pperiod = period_register_2;
            ptick   = period_tick_2;
         end
         ccp_pkg::TSEL_C: begin
            ptimer  = period_timer_4;
            pperiod = period_register_4;
            ptick   = period_tick_4;
         end
         default: begin
            ptimer  = period_timer_6;
            pperiod = period_register_6;
            ptick   = period_tick_6;
         end
      endcase
   end

   // Duty value from the register pair by alignment
   always_comb begin
      if (width_alignment_bit) begin
         pulse_width_value = {value_high_byte_q, value_low_byte_q[7:6]};
      end else begin
         pulse_width_value = {value_high_byte_q[1:0], value_low_byte_q};
      end
   end

   always_comb begin
      eq      = ({value_high_byte_q, value_low_byte_q} == ctimer);
      match   = is_cmp && eq && !eq_prev_q;
      pwm_end = is_pwm && ptick && (ptimer == pperiod);
      pwm_hit = is_pwm && ({ptimer, phase_q} == duty_q - 10'h001); // Output flop lags one count
   end

   assign cap_raw = {logic_cell_output, pin_change_event, numeric_oscillator_output,
                     comparator_2_output, comparator_1_output, routed_pin_input};

   ccp_capture_edge #(
      .N(ccp_pkg::SRC_NUM)
   ) u_cap (
      .clk     (clk),
      .rst_n   (rst_n),
      .raw_in  (cap_raw),
      .src_sel (capture_source_field_q),
      .mode    (function_code),
      .active  (is_cap),
      .cap_q   (cap_ev)
   );

   // APB slave: ready in the first access cycle
   always_comb begin
      wr_en = psel && penable && pready_q && pwrite;
      rd_en = psel && !penable;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end else begin
         pready_q  <= rd_en;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
         if (rd_en) begin
            case (paddr)
               ccp_pkg::OFF_MODE: prdata_q <= {24'h0, mode_control_q[7], 1'b0, out_q,
                                               mode_control_q[4:0]};
               ccp_pkg::OFF_CAP:  prdata_q <= {28'h0, capture_source_field_q};
               ccp_pkg::OFF_LOW:  prdata_q <= {24'h0, value_low_byte_q};
               ccp_pkg::OFF_HIGH: prdata_q <= {24'h0, value_high_byte_q};
               ccp_pkg::OFF_TMRS: prdata_q <= {24'h0, unit_timer_select_q};
               default:           pslverr_q <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_control_q         <= ccp_pkg::MODE_RST;
         capture_source_field_q <= ccp_pkg::CAP_RST;
         unit_timer_select_q    <= ccp_pkg::TMRS_RST;
      end else if (wr_en) begin
         case (paddr)
            ccp_pkg::OFF_MODE: mode_control_q <= {pwdata[7], 2'b00, pwdata[4:0]};
            ccp_pkg::OFF_CAP:  capture_source_field_q <= pwdata[3:0];
            ccp_pkg::OFF_TMRS: unit_timer_select_q <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Value pair: capture hardware wins over a software write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         value_low_byte_q  <= ccp_pkg::VAL_RST;
         value_high_byte_q <= ccp_pkg::VAL_RST;
      end else if (cap_ev && is_cap) begin
         value_low_byte_q  <= ctimer[7:0];
         value_high_byte_q <= ctimer[15:8];
      end else if (wr_en && paddr == ccp_pkg::OFF_LOW) begin
         value_low_byte_q  <= pwdata[7:0];
      end else if (wr_en && paddr == ccp_pkg::OFF_HIGH) begin
         value_high_byte_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || !is_cmp) begin
         eq_prev_q <= 1'b0;
      end else begin
         eq_prev_q <= eq;
      end
   end

   // Time base low bits run on the system clock
   always_ff @(posedge clk) begin
      if (!rst_n || !is_pwm || ptick) begin
         phase_q <= '0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || !active) begin
         duty_q <= '0;
      end else if (pwm_end) begin
         duty_q <= pulse_width_value;
      end
   end

   // Output level
   always_ff @(posedge clk) begin
      if (!rst_n || !active) begin
         out_q   <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         pulse_q <= 1'b0;
         if (pulse_q) begin
            out_q <= 1'b0;
         end
         if (match) begin
            case (function_code)
               ccp_pkg::CCP_CMP_PLS_CL, ccp_pkg::CCP_CMP_PLS: begin
                  out_q   <= 1'b1;
                  pulse_q <= 1'b1;
               end
               ccp_pkg::CCP_CMP_CLR:    out_q <= 1'b0;
               ccp_pkg::CCP_CMP_SET:    out_q <= 1'b1;
               ccp_pkg::CCP_CMP_TGL, ccp_pkg::CCP_CMP_TGL_CL: out_q <= !out_q;
               default: ;
            endcase
         end
         if (pwm_end) begin
            out_q <= (pulse_width_value != '0);
         end else if (pwm_hit) begin
            out_q <= 1'b0;
         end
      end
   end

   // Events, timer clears and converter trigger
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         event_q         <= 1'b0;
         adc_q           <= 1'b0;
         tclr_q          <= 1'b0;
         pclr_q          <= 1'b0;
         oe_q            <= 1'b0;
         timer_clear_sel <= '0;
      end else begin
         event_q <= match || (cap_ev && is_cap) || pwm_end;
         adc_q   <= adc_source_is_unit && (match || (cap_ev && is_cap) || pwm_end);
         tclr_q  <= match && (function_code == ccp_pkg::CCP_CMP_PLS_CL ||
                              function_code == ccp_pkg::CCP_CMP_TGL_CL);
         pclr_q  <= pwm_end;
         oe_q    <= is_cmp || is_pwm;
         timer_clear_sel <= timer_selection_field;
      end
   end

   assign ccp_out          = out_q;
   assign ccp_oe           = oe_q;
   assign match_event_flag = event_q;
   assign adc_trigger      = adc_q;
   assign timer_clear      = tclr_q;
   assign period_clear     = pclr_q;
   assign prdata           = prdata_q;
   assign pready           = pready_q;
   assign pslverr          = pslverr_q;

   a_reset_pin_input: assert property (@(posedge clk)
      !rst_n |=> !ccp_oe && !ccp_out) else $error("pin not input after reset");
   a_disable_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      !unit_enable_bit ##1 !unit_enable_bit |-> !ccp_out && !match_event_flag) else $error("disabled unit active");
   a_bit6_zero: assert property (@(posedge clk) disable iff (!rst_n)
      !mode_control_q[6] && !mode_control_q[5]) else $error("bit 6 or stored bit 5 set");
   a_pulse_shape: assert property (@(posedge clk) disable iff (!rst_n)
      match && function_code == ccp_pkg::CCP_CMP_PLS && !pwm_end |=> ccp_out ##1 !ccp_out)
      else $error("pulse shape wrong");
   a_clear_low: assert property (@(posedge clk) disable iff (!rst_n)
      match && function_code == ccp_pkg::CCP_CMP_CLR |=> !ccp_out) else $error("clear on match failed");
   a_toggle_clr: assert property (@(posedge clk) disable iff (!rst_n)
      match && function_code == ccp_pkg::CCP_CMP_TGL_CL |=> timer_clear && ccp_out != $past(ccp_out))
      else $error("toggle with clear failed");
   a_event_flag: assert property (@(posedge clk) disable iff (!rst_n)
      (match || pwm_end) |=> match_event_flag && (adc_trigger == $past(adc_source_is_unit)))
      else $error("event flag missing");
   a_cap_store: assert property (@(posedge clk) disable iff (!rst_n)
      cap_ev && is_cap |=> {value_high_byte_q, value_low_byte_q} == $past(ctimer))
      else $error("capture value wrong");
   a_pwm_zero: assert property (@(posedge clk) disable iff (!rst_n)
      pwm_end && pulse_width_value == '0 |=> !ccp_out && period_clear) else $error("zero duty set pin");
   a_pwm_hit: assert property (@(posedge clk) disable iff (!rst_n)
      pwm_hit && !pwm_end |=> !ccp_out) else $error("duty match kept pin");
   a_reserved_none: assert property (@(posedge clk) disable iff (!rst_n)
      function_code inside {ccp_pkg::CCP_RSV_C, ccp_pkg::CCP_RSV_D, ccp_pkg::CCP_RSV_E}
      ##1 $stable(function_code) |-> !match_event_flag) else $error("event in reserved mode");
endmodule

// ==== testbench/ccp_far_model.sv ====
`timescale 1ns/1ns
module ccp_far_model #(
   parameter logic [7:0] PER = 8'h03
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       timer_clear,
   input  wire logic [1:0] timer_clear_sel,
   input  wire logic       period_clear,
   output logic [15:0]     tmr_q,
   output logic [7:0]      ptmr_q,
   output logic [7:0]      per,
   output logic            tick
);
   logic [1:0] pre_q;
   assign per  = PER;
   assign tick = (pre_q == 2'h3);
   // Free running timer, cleared only when this timer is the one selected
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tmr_q <= 16'h0000;
      end else if (timer_clear && timer_clear_sel == 2'h1) begin
         tmr_q <= 16'h0000;
      end else begin
         tmr_q <= tmr_q + 16'h0001;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pre_q <= 2'h0;
      end else begin
         pre_q <= pre_q + 2'h1;
      end
   end
   // Period timer steps every fourth clock and wraps after the period
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ptmr_q <= 8'h00;
      end else if (tick) begin
         ptmr_q <= (ptmr_q == PER || period_clear) ? 8'h00 : ptmr_q + 8'h01;
      end
   end
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
module testbench;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pin = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, ccp_out, ccp_oe, match_event_flag, adc_trigger, timer_clear, period_clear;
   logic [1:0]  timer_clear_sel;
   logic [15:0] tmr;
   logic [7:0]  ptmr, per;
   logic        tick, saw_hi = 1'b0, saw_clr = 1'b0, adc_src = 1'b1;
   int          err_count = 0, n_tests = 0, n_ev = 0;

   ccp_far_model i_ccp_far_model (.clk(clk), .rst_n(rst_n), .timer_clear(timer_clear),
      .timer_clear_sel(timer_clear_sel), .period_clear(period_clear), .tmr_q(tmr), .ptmr_q(ptmr),
      .per(per), .tick(tick));
   ccp_unit i_ccp_unit (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sixteen_bit_timer_0(tmr ^ 16'h5555), .sixteen_bit_timer_1(tmr), .sixteen_bit_timer_3(~tmr),
      .sixteen_bit_timer_5(tmr + 16'h0100), .period_timer_2(ptmr), .period_timer_4(~ptmr),
      .period_timer_6(~ptmr), .period_register_2(per), .period_register_4(per),
      .period_register_6(per), .period_tick_2(tick), .period_tick_4(tick), .period_tick_6(tick),
      .adc_source_is_unit(adc_src), .routed_pin_input(pin), .comparator_1_output(1'b0),
      .comparator_2_output(1'b0), .numeric_oscillator_output(1'b0), .pin_change_event(1'b0),
      .logic_cell_output(4'h0), .ccp_out(ccp_out), .ccp_oe(ccp_oe), .match_event_flag(match_event_flag),
      .adc_trigger(adc_trigger), .timer_clear(timer_clear), .timer_clear_sel(timer_clear_sel),
      .period_clear(period_clear));

   always #50 clk = ~clk;
   always @(posedge clk) begin
      if (ccp_out === 1'b1) saw_hi <= 1'b1;
      if (timer_clear === 1'b1) saw_clr <= 1'b1;
      if (match_event_flag === 1'b1) n_ev <= n_ev + 1;
   end

   task automatic give_verdict();
      $display("errors %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask
   task automatic wflag();
      int i;
      for (i = 0; i < 100; i++) begin
         @(posedge clk);
         if (match_event_flag === 1'b1) break;
      end
      chk(match_event_flag, 1);
      chk(adc_trigger, 1);
   endtask

   task automatic t_reset();
      logic [31:0] r;
      logic        e;
      rd(ccp_pkg::OFF_MODE, 32'h00);
      rd(ccp_pkg::OFF_CAP, 32'h00);
      rd(ccp_pkg::OFF_LOW, 32'h00);
      rd(ccp_pkg::OFF_HIGH, 32'h00);
      rd(ccp_pkg::OFF_TMRS, 32'h55);
      chk(ccp_oe, 0);
      apb(1'b0, 8'h14, 32'h0, r, e);
      chk({31'h0, e}, 1);
      wr(ccp_pkg::OFF_MODE, 8'h70);
      rd(ccp_pkg::OFF_MODE, 32'h10);
   endtask
   task automatic t_cmp();
      logic [3:0]  cd [8] = '{4'h8, 4'h9, 4'h8, 4'h0, 4'h2, 4'h1, 4'ha, 4'hb};
      logic [7:0]  ex = 8'b10101000, pl = 8'b00000011, cl = 8'b00000101;
      logic [15:0] tv;
      int          k;
      for (k = 0; k < 8; k++) begin
         tv = tmr + 16'd40;
         wr(ccp_pkg::OFF_LOW, tv[7:0]);
         wr(ccp_pkg::OFF_HIGH, tv[15:8]);
         saw_hi <= 1'b0;
         saw_clr <= 1'b0;
         wr(ccp_pkg::OFF_MODE, {4'h8, cd[k]});
         if (cd[k] != 4'h0) wflag();
         repeat (3) @(posedge clk);
         chk(ccp_out, ex[7-k]);
         if (pl[7-k]) chk(saw_hi, 1);
         chk(saw_clr, cl[7-k]);
         rd(ccp_pkg::OFF_MODE, {24'h0, 2'b10, ex[7-k], 1'b0, cd[k]});
      end
   endtask
   task automatic t_cap();
      logic [3:0]  md [8] = '{4'h5, 4'h4, 4'h3, 4'h6, 4'h7, 4'h5, 4'h5, 4'hc};
      logic [3:0]  sr [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h9, 4'h0};
      int          nx [8] = '{16, 16, 32, 4, 1, 0, 0, 0};
      int          k, j, base;
      logic [31:0] lo, hi;
      logic        e;
      logic [15:0] t0;
      for (k = 0; k < 8; k++) begin
         wr(ccp_pkg::OFF_MODE, 8'h00);
         wr(ccp_pkg::OFF_CAP, {4'h0, sr[k]});
         wr(ccp_pkg::OFF_MODE, {4'h8, md[k]});
         repeat (4) @(posedge clk);
         base = n_ev;
         for (j = 0; j < 16; j++) begin
            pin <= 1'b1;
            repeat (4) @(posedge clk);
            pin <= 1'b0;
            repeat (4) @(posedge clk);
         end
         repeat (8) @(posedge clk);
         chk(n_ev - base, nx[k]);
      end
      wr(ccp_pkg::OFF_MODE, 8'h00);
      wr(ccp_pkg::OFF_CAP, 8'h00);
      wr(ccp_pkg::OFF_MODE, 8'h85);
      @(posedge clk);
      pin <= 1'b1;
      t0 = tmr;
      wflag();
      apb(1'b0, ccp_pkg::OFF_LOW, 32'h0, lo, e);
      apb(1'b0, ccp_pkg::OFF_HIGH, 32'h0, hi, e);
      chk(({hi[7:0], lo[7:0]} - t0) < 16'd16, 1);
   endtask
   task automatic t_pwm();
      logic [7:0] lo [3] = '{8'h06, 8'hbf, 8'h00};
      logic [7:0] hi [3] = '{8'hfc, 8'h01, 8'h00};
      logic [7:0] md [3] = '{8'h8f, 8'h9f, 8'h8f};
      int         nx [3] = '{12, 12, 0};
      int         f, j, n;
      for (f = 0; f < 3; f++) begin
         adc_src <= (f != 2);
         wr(ccp_pkg::OFF_LOW, lo[f]);
         wr(ccp_pkg::OFF_HIGH, hi[f]);
         wr(ccp_pkg::OFF_MODE, md[f]);
         repeat (40) @(posedge clk);
         n = 0;
         for (j = 0; j < 32; j++) begin
            @(posedge clk);
            if (ccp_out === 1'b1) n++;
         end
         chk(n, nx[f]);
         chk(ccp_oe, 1);
      end
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_cmp();
      t_cap();
      t_pwm();
      give_verdict();
   end
   initial begin
      #(100 * 20000);
      err_count++;
      give_verdict();
   end
endmodule
